// ==== shared/adc_pin_pkg.sv ====
// Shared constants and carrier types for the converter pin control block
package adc_pin_pkg;
  localparam int CHANNELS_MAX = 8;
  localparam int SAMPLE_BITS = 16;
  localparam int FULL_CHANNELS = 8;
  localparam int QUAD_CHANNELS = 4;
  // Speed select pin levels
  localparam logic SPEED_HIGH = 1'h0;
  localparam logic SPEED_LOW_POWER = 1'h1;
  // Expected master clock, kHz
  localparam int MCLK_FULL_KHZ = 27000;
  localparam int MCLK_HALF_HS_KHZ = 13500;
  localparam int MCLK_HALF_LP_KHZ = 5400;
  localparam int SYS_CLK_KHZ = 125000;
  // Scan select codes
  localparam logic [1:0] SCAN_NORMAL = 2'h0;
  localparam logic [1:0] SCAN_BOUNDARY = 2'h3;
  // Layout select field positions
  localparam int LAYOUT_PROTO_BIT = 0;
  localparam int LAYOUT_TDM_BIT = 1;
  localparam int LAYOUT_DYN_BIT = 2;
  localparam logic [2:0] LAYOUT_RESET = 3'h0;
  // Conversion period in master clock periods, per mode and divider
  localparam int CONV_HS_PERIODS = 512;
  localparam int CONV_LP_PERIODS = 2560;
  localparam int CONV_DIV_PERIODS = 256;
  localparam logic [11:0] CONV_CNT_RESET = 12'h000;
  localparam int MCLK_TO_READY_CYCLES = 1;

  typedef enum logic [1:0] {
    PROTO_SPI = 2'h0,
    PROTO_FRAME = 2'h1
  } proto_t;

  typedef struct packed {
    logic low_power;
    logic clk_full;
    logic [1:0] scan_sel;
    logic [2:0] layout;
  } cfg_t;

  typedef struct packed {
    logic [SAMPLE_BITS-1:0] data;
    logic [2:0] chan;
  } sample_t;
endpackage : adc_pin_pkg

// ==== design/sample_buf2.sv ====
// Two-entry valid/ready buffer carrying channel samples
`timescale 1ns/10ps
module sample_buf2
  import adc_pin_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic i_valid, // Fill side valid
  output logic o_ready, // Fill side ready
  input wire sample_t i_data, // Fill side word
  output logic o_valid, // Drain side valid
  input wire logic i_ready, // Drain side ready
  output sample_t o_data // Drain side word
);
  sample_t mem_reg [2];
  logic [1:0] count_reg;
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic push;
  logic pop;

  assign o_ready = (count_reg != 2'h2);
  assign o_valid = (count_reg != 2'h0);
  assign o_data = mem_reg[rd_ptr_reg];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 2'h0;
      wr_ptr_reg <= 1'h0;
      rd_ptr_reg <= 1'h0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      if (push && !pop) count_reg <= count_reg + 2'h1;
      else if (pop && !push) count_reg <= count_reg - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem_reg[wr_ptr_reg] <= i_data;
  end
endmodule : sample_buf2

// ==== design/adc_pin_control.sv ====
// Pin-driven control, conversion timing and serial output of the converter
//
// Function
// - Speed select low gives high-speed mode, high gives low-power mode.
// - Divider select high expects a full-rate master clock, low a reduced one.
// - Scan select 00 is normal operation and 11 boundary scan.
// - Ready/frame pin is a frame input in frame-sync and a ready output in SPI.
// - Multiplexed layout sends every channel on the first data output alone.
// - Discrete layout gives each channel its own data output.
// - On the quad variant the four upper data outputs are still driven.
// - Each channel has its own power-down input acting on it alone.
// - Layout select chooses protocol, multiplexing and modulator mode.
// - One synchronize input realigns conversions of all channels together.
`timescale 1ns/10ps
module adc_pin_control
  import adc_pin_pkg::*;
#(
  parameter int NUM_CH = 8 // 8 octal, 4 quad
)(
  input wire logic I_SYS_CLK, // System clock
  input wire logic I_RESETN, // Reset, active low
  input wire logic I_MCLK_EN, // Master clock pulse
  input wire logic I_SPEED_SEL, // 0 high-speed, 1 low-power
  input wire logic I_MASTER_CLOCK_DIVIDER_SELECT, // 1 full-rate clock
  input wire logic [1:0] I_SCAN_SEL, // Test mode select
  input wire logic [2:0] I_LAYOUT_SEL, // Protocol and layout select
  input wire logic [CHANNELS_MAX-1:0] I_CHANNEL_POWERDOWN, // Per channel
  input wire logic I_SYNC, // Synchronize, realigns all channels
  input wire logic I_SCLK, // Shift clock level
  input wire logic I_DAISY_IN, // Daisy-chain data input
  input wire logic I_READY_OR_FRAME_STROBE, // Frame clock input pin level
  input wire logic [CHANNELS_MAX-1:0] I_MOD_BIT, // Modulator bits
  input wire logic I_SAMPLE_VALID, // Filter result valid
  output logic O_SAMPLE_READY, // Filter result accepted
  input wire sample_t I_SAMPLE, // Filter result word
  output logic O_READY_OR_FRAME_STROBE, // Data-ready output, active low
  output logic O_READY_OR_FRAME_STROBE_OE, // High while driving the pin
  output logic [CHANNELS_MAX-1:0] O_DOUT, // Serial data outputs
  output logic [CHANNELS_MAX-1:0] O_CH_ACTIVE, // Channel powered
  output logic O_LOW_POWER, // Low-power mode active
  output logic O_SCAN_MODE, // Boundary scan active
  output logic [11:0] O_CONV_PERIOD, // Master clocks per conversion
  output logic O_CONV_START // One pulse per conversion
);
  logic rst_s1_reg;
  logic rst_n;
  cfg_t cfg;
  logic frame_mode;
  logic tdm_mode;
  logic mod_mode;
  logic [11:0] conv_len;
  logic [11:0] conv_cnt_reg;
  logic sync_d_reg;
  logic sclk_d_reg;
  logic frame_d_reg;
  logic sclk_fall;
  logic frame_rise;
  logic shift_go;
  logic buf_valid;
  logic buf_ready;
  sample_t buf_data;
  logic [SAMPLE_BITS-1:0] shift_reg;
  logic [4:0] bit_cnt_reg;
  logic [2:0] chan_reg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_READY = 2'h1,
    ST_SHIFT = 2'h3
  } out_state_t;
  out_state_t state_reg;

  function automatic logic [11:0] conv_periods(input logic lp,
                                              input logic full);
    if (!full) conv_periods = 12'(CONV_DIV_PERIODS);
    else if (lp) conv_periods = 12'(CONV_LP_PERIODS);
    else conv_periods = 12'(CONV_HS_PERIODS);
  endfunction : conv_periods

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_s1_reg <= 1'h0;
      rst_n <= 1'h0;
    end else begin
      rst_s1_reg <= 1'h1;
      rst_n <= rst_s1_reg;
    end
  end

  assign cfg = '{low_power: I_SPEED_SEL,
                 clk_full: I_MASTER_CLOCK_DIVIDER_SELECT,
                 scan_sel: I_SCAN_SEL, layout: I_LAYOUT_SEL};
  assign frame_mode = cfg.layout[LAYOUT_PROTO_BIT];
  assign tdm_mode = cfg.layout[LAYOUT_TDM_BIT];
  assign mod_mode = (cfg.layout == 3'h7); // Modulator output
  assign conv_len = conv_periods(cfg.low_power, cfg.clk_full);
  assign sclk_fall = sclk_d_reg && !I_SCLK;
  assign frame_rise = !frame_d_reg && I_READY_OR_FRAME_STROBE;

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_LOW_POWER <= 1'h0;
      O_SCAN_MODE <= 1'h0;
      O_CONV_PERIOD <= CONV_CNT_RESET;
      O_CH_ACTIVE <= '0;
    end else begin
      O_LOW_POWER <= (cfg.low_power == SPEED_LOW_POWER);
      O_SCAN_MODE <= (cfg.scan_sel == SCAN_BOUNDARY);
      O_CONV_PERIOD <= conv_len;
      for (int i = 0; i < CHANNELS_MAX; i++) begin
        O_CH_ACTIVE[i] <= (i < NUM_CH) && !I_CHANNEL_POWERDOWN[i];
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sync_d_reg <= 1'h0;
      sclk_d_reg <= 1'h0;
      frame_d_reg <= 1'h0;
    end else begin
      sync_d_reg <= I_SYNC;
      sclk_d_reg <= I_SCLK;
      frame_d_reg <= I_READY_OR_FRAME_STROBE;
    end
  end

  // Rising sync restarts the shared counter, so all channels realign
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      conv_cnt_reg <= CONV_CNT_RESET;
      O_CONV_START <= 1'h0;
    end else begin
      O_CONV_START <= 1'h0;
      if (I_SYNC && !sync_d_reg) begin
        conv_cnt_reg <= CONV_CNT_RESET;
      end else if (I_MCLK_EN && cfg.scan_sel == SCAN_NORMAL) begin
        if (conv_cnt_reg >= conv_len - 12'h1) begin
          conv_cnt_reg <= CONV_CNT_RESET;
          O_CONV_START <= 1'h1;
        end else begin
          conv_cnt_reg <= conv_cnt_reg + 12'h1;
        end
      end
    end
  end

  // Buffer absorbs a word while the host has not shifted the last one out
  sample_buf2 u_buf (
    .clk(I_SYS_CLK),
    .rst_n(rst_n),
    .i_valid(I_SAMPLE_VALID && O_CH_ACTIVE[I_SAMPLE.chan]),
    .o_ready(buf_ready),
    .i_data(I_SAMPLE),
    .o_valid(buf_valid),
    .i_ready(shift_go),
    .o_data(buf_data)
  );

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) O_SAMPLE_READY <= 1'h0;
    else O_SAMPLE_READY <= buf_ready;
  end

  assign shift_go = (state_reg == ST_IDLE) && buf_valid;

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      shift_reg <= '0;
      bit_cnt_reg <= 5'h00;
      chan_reg <= 3'h0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (shift_go) begin
            shift_reg <= buf_data.data;
            chan_reg <= buf_data.chan;
            bit_cnt_reg <= 5'(SAMPLE_BITS);
            state_reg <= ST_READY;
          end
        end
        ST_READY: begin
          // Frame-sync waits for the host frame edge, SPI for first fall
          if (frame_mode ? frame_rise : sclk_fall) begin
            if (!frame_mode) begin
              // MSB already stood since ready, so this fall moves on
              shift_reg <= {shift_reg[SAMPLE_BITS-2:0], I_DAISY_IN};
              bit_cnt_reg <= bit_cnt_reg - 5'h01;
            end
            state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (sclk_fall) begin
            shift_reg <= {shift_reg[SAMPLE_BITS-2:0], I_DAISY_IN};
            bit_cnt_reg <= bit_cnt_reg - 5'h01;
            if (bit_cnt_reg == 5'h01) begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_READY_OR_FRAME_STROBE <= 1'h1;
      O_READY_OR_FRAME_STROBE_OE <= 1'h0;
    end else begin
      O_READY_OR_FRAME_STROBE_OE <= !frame_mode;
      O_READY_OR_FRAME_STROBE <= !(state_reg == ST_READY);
    end
  end

  // Unused quad outputs are driven low, never released
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_DOUT <= '0;
    end else begin
      O_DOUT <= '0;
      if (mod_mode) begin
        O_DOUT <= I_MOD_BIT & O_CH_ACTIVE;
      end else if (tdm_mode) begin
        O_DOUT[0] <= shift_reg[SAMPLE_BITS-1];
      end else if ({1'b0, chan_reg} < 4'(NUM_CH)) begin
        O_DOUT[chan_reg] <= shift_reg[SAMPLE_BITS-1];
      end
    end
  end
endmodule : adc_pin_control

// ==== sim/adc_pin_control_asserts.sv ====
// Port checks for the converter pin control block
`timescale 1ns/10ps
module adc_pin_control_asserts
  import adc_pin_pkg::*;
#(
  parameter int NUM_CH = 8 // Channels present
)(
  input wire logic I_SYS_CLK, // Clock
  input wire logic I_RESETN, // Reset, active low
  input wire logic I_SPEED_SEL, // Mode pin
  input wire logic I_MASTER_CLOCK_DIVIDER_SELECT, // Divider pin
  input wire logic [1:0] I_SCAN_SEL, // Test pins
  input wire logic [2:0] I_LAYOUT_SEL, // Layout pins
  input wire logic [CHANNELS_MAX-1:0] I_CHANNEL_POWERDOWN, // Power-down
  input wire logic [CHANNELS_MAX-1:0] I_MOD_BIT, // Modulator bits
  input wire logic O_READY_OR_FRAME_STROBE_OE, // Pin enable
  input wire logic [CHANNELS_MAX-1:0] O_DOUT, // Data outputs
  input wire logic [CHANNELS_MAX-1:0] O_CH_ACTIVE, // Powered channels
  input wire logic O_LOW_POWER, // Mode out
  input wire logic O_SCAN_MODE, // Scan out
  input wire logic [11:0] O_CONV_PERIOD, // Period out
  input wire logic O_CONV_START // Conversion pulse
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);
  logic [2:0] up_reg;
  logic run;
  // Outputs mean nothing until the two-flop reset copy lets go
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) up_reg <= 3'h0;
    else up_reg <= {up_reg[1:0], 1'b1};
  end
  assign run = &up_reg;
  sequence s_spi; run && !I_LAYOUT_SEL[0]; endsequence
  sequence s_frame; run && I_LAYOUT_SEL[0]; endsequence
  sequence s_tdm; (run && I_LAYOUT_SEL == 3'h2) [*3]; endsequence
  sequence s_mod; (run && I_LAYOUT_SEL == 3'h7) [*3]; endsequence
  AST_LOW_POWER: assert property (
    run |-> O_LOW_POWER == $past(I_SPEED_SEL))
    else $error("low power flag wrong");
  AST_CONV_PERIOD: assert property (
    run |-> O_CONV_PERIOD == ($past(I_MASTER_CLOCK_DIVIDER_SELECT) ?
    ($past(I_SPEED_SEL) ? 12'hA00 : 12'h200) : 12'h100))
    else $error("conversion period wrong");
  AST_SCAN_MODE: assert property (
    run |-> O_SCAN_MODE == ($past(I_SCAN_SEL) == 2'h3))
    else $error("scan flag wrong");
  AST_OE_SPI: assert property (s_spi [*2] |-> O_READY_OR_FRAME_STROBE_OE)
    else $error("ready pin not driven in SPI");
  AST_OE_FRAME: assert property (
    s_frame [*2] |-> !O_READY_OR_FRAME_STROBE_OE)
    else $error("frame pin driven in frame-sync");
  AST_CH_ACTIVE: assert property (run |-> O_CH_ACTIVE ==
    (~$past(I_CHANNEL_POWERDOWN) & (8'hFF >> (CHANNELS_MAX - NUM_CH))))
    else $error("channel active flags wrong");
  AST_TDM_FIRST: assert property (s_tdm |-> O_DOUT[7:1] == 7'h00)
    else $error("TDM data off the first output");
  AST_MOD_PASS: assert property (s_mod |-> O_DOUT == $past(I_MOD_BIT))
    else $error("modulator bits not passed");
  AST_START_PULSE: assert property (O_CONV_START |=> !O_CONV_START)
    else $error("conversion start longer than a cycle");
endmodule : adc_pin_control_asserts
bind adc_pin_control adc_pin_control_asserts #(.NUM_CH(NUM_CH)) i_chk (
  .I_SYS_CLK, .I_RESETN, .I_SPEED_SEL, .I_MASTER_CLOCK_DIVIDER_SELECT,
  .I_SCAN_SEL, .I_LAYOUT_SEL, .I_CHANNEL_POWERDOWN, .I_MOD_BIT,
  .O_READY_OR_FRAME_STROBE_OE, .O_DOUT, .O_CH_ACTIVE, .O_LOW_POWER,
  .O_SCAN_MODE, .O_CONV_PERIOD, .O_CONV_START);

// ==== sim/adc_host_model.sv ====
// Host side model reading one word per ready strobe in SPI
`timescale 1ns/10ps
module adc_host_model #(
  parameter int HALF = 4 // System cycles per shift clock half
)(
  input wire logic clk, // System clock
  input wire logic ready_n, // Ready strobe, active low
  input wire logic [2:0] lane, // Output watched
  input wire logic [7:0] dout, // Serial outputs
  output logic sclk, // Shift clock
  output logic [15:0] word, // Last word read
  output logic done // Toggles per word
);
  initial begin
    sclk = 1'b0;
    word = 16'h0000;
    done = 1'b0;
    forever begin
      @(negedge clk);
      if (ready_n === 1'b0) begin
        // Six cycles exceed one master clock period
        repeat (6) @(negedge clk);
        for (int b = 15; b >= 0; b--) begin
          sclk = 1'b1;
          repeat (HALF) @(negedge clk);
          word[b] = dout[lane];
          sclk = 1'b0;
          repeat (HALF) @(negedge clk);
        end
        done = ~done;
      end
    end
  end
endmodule : adc_host_model

// ==== sim/adc_pin_control_tb_top.sv ====
// Self-checking bench for the converter pin control block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  failures++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module adc_pin_control_tb_top;
  import adc_pin_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, men = 1'b0, spd = 1'b0, div = 1'b1;
  logic sync = 1'b0, vld = 1'b0, srdy, stb, oe, lp, scm, start, sclk, done;
  logic [1:0] scan = 2'h0;
  logic [2:0] lay = 3'h0, lane = 3'h0;
  logic [7:0] pd = 8'h00, mods = 8'h00, dout, act;
  logic [11:0] per;
  logic [15:0] word, got;
  sample_t smp = '0;
  int failures = 0, n_compared = 0, mc = 0;
  always #4 clk = ~clk;
  // Master clock pulse every 5 cycles, 25 MHz
  always @(negedge clk) begin
    mc <= (mc == 4) ? 0 : mc + 1;
    men <= (mc == 4);
  end
  adc_pin_control #(.NUM_CH(8)) i_adc_pin_control (
    .I_SYS_CLK(clk), .I_RESETN(rst_n), .I_MCLK_EN(men), .I_SPEED_SEL(spd),
    .I_MASTER_CLOCK_DIVIDER_SELECT(div), .I_SCAN_SEL(scan),
    .I_LAYOUT_SEL(lay), .I_CHANNEL_POWERDOWN(pd), .I_SYNC(sync),
    .I_SCLK(sclk), .I_DAISY_IN(1'b0), .I_READY_OR_FRAME_STROBE(1'b0),
    .I_MOD_BIT(mods), .I_SAMPLE_VALID(vld), .O_SAMPLE_READY(srdy),
    .I_SAMPLE(smp), .O_READY_OR_FRAME_STROBE(stb),
    .O_READY_OR_FRAME_STROBE_OE(oe), .O_DOUT(dout), .O_CH_ACTIVE(act),
    .O_LOW_POWER(lp), .O_SCAN_MODE(scm), .O_CONV_PERIOD(per),
    .O_CONV_START(start));
  adc_host_model i_adc_host_model (.clk(clk), .ready_n(stb), .lane(lane),
    .dout(dout), .sclk(sclk), .word(word), .done(done));
  task automatic push(input logic [2:0] ch, input logic [15:0] d);
    for (int n = 0; n < 50 && srdy !== 1'b1; n++) @(negedge clk);
    smp = {d, ch};
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
  endtask : push
  task automatic read(input logic [2:0] ln, output logic [15:0] w);
    logic d0;
    lane = ln;
    d0 = done;
    for (int n = 0; n < 3000 && done === d0; n++) @(negedge clk);
    w = word;
  endtask : read
  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      {div, spd} = i[1:0];
      scan = i[1:0];
      lay = {2'h0, i[0]};
      repeat (2) @(negedge clk);
      `CHK("low power", i[0], lp)
      `CHK("period", i[1] ? (i[0] ? 12'hA00 : 12'h200) : 12'h100, per)
      `CHK("scan", i == 3, scm)
      `CHK("pin enable", !i[0], oe)
    end
    {div, spd, scan, lay} = {2'h2, 2'h0, 3'h0};
    for (int c = 0; c < 8; c++) begin
      pd = 8'h01 << c;
      repeat (2) @(negedge clk);
      `CHK("active", ~(8'h01 << c), act)
    end
    // Channel five down; its word must never raise ready
    pd = 8'h20;
    repeat (2) @(negedge clk);
    push(3'h5, 16'h1234);
    repeat (3) @(negedge clk);
    `CHK("refused", 1'b1, stb)
    pd = 8'h00;
    repeat (2) @(negedge clk);
  endtask : t_modes
  task automatic t_data();
    push(3'h5, 16'hA5C3);
    push(3'h2, 16'h3C5A);
    read(3'h5, got);
    `CHK("discrete 5", 16'hA5C3, got)
    read(3'h2, got);
    `CHK("discrete 2", 16'h3C5A, got)
    lay = 3'h2;
    repeat (3) @(negedge clk);
    push(3'h6, 16'h8001);
    read(3'h0, got);
    `CHK("tdm", 16'h8001, got)
    lay = 3'h7;
    for (int k = 0; k < 2; k++) begin
      mods = k ? 8'hA5 : 8'h5A;
      repeat (4) @(negedge clk);
      `CHK("modulator", mods, dout)
    end
    lay = 3'h0;
  endtask : t_data
  task automatic t_sync();
    int n;
    div = 1'b0;
    sync = 1'b1;
    @(negedge clk);
    sync = 1'b0;
    for (n = 0; n < 1500 && start !== 1'b1; n++) @(negedge clk);
    `CHK("start after sync", 1'b1, start)
    @(negedge clk);
    for (n = 1; n < 1500 && start !== 1'b1; n++) @(negedge clk);
    `CHK("conversion cycles", 1280, n)
  endtask : t_sync
  task automatic conclude();
    $display("compared %0d, failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  initial begin
    #400000;
    failures++;
    conclude();
  end
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_modes();
    t_data();
    t_sync();
    conclude();
  end
endmodule : adc_pin_control_tb_top
